// >>> rtl/msc_params.svh
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
// Register indices; the bus word address is the index times four
`define MSC_IDX_A 24'hFFFDC8
`define MSC_IDX_B 24'hFFFDCA
`define MSC_IDX_C 24'hFFFDCC
`define MSC_ADDR_A 26'h3FFF720
`define MSC_ADDR_B 26'h3FFF728
`define MSC_ADDR_C 26'h3FFF730
// Writable bit masks per register
`define MSC_MASK_A 16'hB329
// Module bits of register A, mode enable excluded
`define MSC_MODS_A 16'h3329
`define MSC_MASK_B 16'h97C0
`define MSC_MASK_C 16'hFC1F
// Reset values: every module stopped except timer unit and RAM, mode off
`define MSC_RST_A 16'h3328
`define MSC_RST_B 16'h97C0
`define MSC_RST_C 16'hFC00
// Field positions
`define MSC_BIT_ALL_CLOCK_STOP_ENABLE_POS 15
`define MSC_BIT_DMA 13
`define MSC_BIT_DTC 12
`define MSC_BIT_T832 9
`define MSC_BIT_T810 8
`define MSC_BIT_DAC 5
`define MSC_BIT_ADC 3
`define MSC_BIT_PTU 0
`define MSC_BIT_PGEN 15
`define MSC_BIT_SER4 12
`define MSC_BIT_SER2 10
`define MSC_BIT_SER1 9
`define MSC_BIT_SER0 8
`define MSC_BIT_TW1 7
`define MSC_BIT_TW0 6
`define MSC_BIT_SER5 15
`define MSC_BIT_SER6 14
`define MSC_BIT_T845 13
`define MSC_BIT_T867 12
`define MSC_BIT_USB 11
`define MSC_BIT_CRC 10
`define MSC_RAM_HI 4
`define MSC_RAM_LO 0
`endif

// >>> rtl/msc_pkg.sv
package msc_pkg;
  typedef logic [15:0] msc_reg_t;
  typedef logic [4:0] msc_ram_t;
endpackage

// >>> rtl/msc_module_stop.sv
`timescale 1ns/10ps
`include "msc_params.svh"
module msc_module_stop (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [25:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cpu_sleep_i,
  output logic stop_dma_ctrl_o,
  output logic stop_transfer_ctrl_o,
  output logic stop_timer8_ch32_o,
  output logic stop_timer8_ch10_o,
  output logic stop_dac_o,
  output logic stop_adc_o,
  output logic stop_pulse_timer_o,
  output logic stop_pulse_generator_o,
  output logic stop_serial4_o,
  output logic stop_serial2_o,
  output logic stop_serial1_o,
  output logic stop_serial0_o,
  output logic stop_twowire1_o,
  output logic stop_twowire0_o,
  output logic stop_serial5_o,
  output logic stop_serial6_o,
  output logic stop_timer8_ch45_o,
  output logic stop_timer8_ch67_o,
  output logic stop_usb_o,
  output logic stop_crc_unit_o,
  output logic [4:0] stop_ram_block_o,
  output logic stop_bus_ctrl_o,
  output logic stop_io_ports_o,
  output logic all_clock_stop_enable_o
);

  msc_pkg::msc_reg_t module_stop_ctrl_a_r;
  msc_pkg::msc_reg_t module_stop_ctrl_b_r;
  msc_pkg::msc_reg_t module_stop_ctrl_c_r;
  logic req;
  logic full_word;
  logic sel_a;
  logic sel_b;
  logic sel_c;
  logic all_stopped;
  logic all_stop_nxt;

  // Reset images of the three registers, read bit by bit for the stop flops
  localparam msc_pkg::msc_reg_t RST_A = `MSC_RST_A;
  localparam msc_pkg::msc_reg_t RST_B = `MSC_RST_B;
  localparam msc_pkg::msc_reg_t RST_C = `MSC_RST_C;
  localparam int RAM_W = `MSC_RAM_HI - `MSC_RAM_LO + 1;

  // Address decode; a write needs both low byte lanes
  assign req = cyc_i && stb_i && !ack_o;
  assign full_word = (sel_i[1:0] == 2'h3);
  assign sel_a = (adr_i == `MSC_ADDR_A);
  assign sel_b = (adr_i == `MSC_ADDR_B);
  assign sel_c = (adr_i == `MSC_ADDR_C);

  // Acknowledge one cycle after the request, mapped or not
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // Register writes, reserved bits masked off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      module_stop_ctrl_a_r <= `MSC_RST_A;
      module_stop_ctrl_b_r <= `MSC_RST_B;
      module_stop_ctrl_c_r <= `MSC_RST_C;
    end
    else if (req && we_i && full_word)
    begin
      if (sel_a)
        module_stop_ctrl_a_r <= dat_i[15:0] & `MSC_MASK_A;
      if (sel_b)
        module_stop_ctrl_b_r <= dat_i[15:0] & `MSC_MASK_B;
      if (sel_c)
        module_stop_ctrl_c_r <= dat_i[15:0] & `MSC_MASK_C;
    end
  end

  // Read data; unmapped addresses and upper bits read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (req && !we_i)
    begin
      if (sel_a)
        dat_o <= {16'h0, module_stop_ctrl_a_r};
      else if (sel_b)
        dat_o <= {16'h0, module_stop_ctrl_b_r};
      else if (sel_c)
        dat_o <= {16'h0, module_stop_ctrl_c_r};
      else
        dat_o <= 32'h0;
    end
  end

  // Every gated module stopped, taken from the current register contents
  assign all_stopped = ((module_stop_ctrl_a_r & `MSC_MODS_A) == `MSC_MODS_A)
    && (module_stop_ctrl_b_r == `MSC_MASK_B)
    && (module_stop_ctrl_c_r == `MSC_MASK_C);
  assign all_stop_nxt = module_stop_ctrl_a_r[`MSC_BIT_ALL_CLOCK_STOP_ENABLE_POS] && all_stopped
    && cpu_sleep_i;

  // Bus controller and port stop, plus mode flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stop_bus_ctrl_o <= 1'b0;
      stop_io_ports_o <= 1'b0;
      all_clock_stop_enable_o <= 1'b0;
    end
    else
    begin
      stop_bus_ctrl_o <= all_stop_nxt;
      stop_io_ports_o <= all_stop_nxt;
      all_clock_stop_enable_o <= module_stop_ctrl_a_r[`MSC_BIT_ALL_CLOCK_STOP_ENABLE_POS];
    end
  end

  // Transfer engines: DMA and data transfer controller
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_DMA])) u_stop_dma (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_DMA]),
    .stop_o(stop_dma_ctrl_o)
  );
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_DTC])) u_stop_dtc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_DTC]),
    .stop_o(stop_transfer_ctrl_o)
  );

  // 8-bit timer pairs in register A
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_T832])) u_stop_t832 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_T832]),
    .stop_o(stop_timer8_ch32_o)
  );
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_T810])) u_stop_t810 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_T810]),
    .stop_o(stop_timer8_ch10_o)
  );

  // Converters
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_DAC])) u_stop_dac (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_DAC]),
    .stop_o(stop_dac_o)
  );
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_ADC])) u_stop_adc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_ADC]),
    .stop_o(stop_adc_o)
  );

  // Pulse timer unit, one line for all six channels
  msc_stop_flop #(.RST_VAL(RST_A[`MSC_BIT_PTU])) u_stop_ptu (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_a_r[`MSC_BIT_PTU]),
    .stop_o(stop_pulse_timer_o)
  );

  // Pulse generator
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_PGEN])) u_stop_pgen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_PGEN]),
    .stop_o(stop_pulse_generator_o)
  );

  // Serial channels in register B
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_SER4])) u_stop_ser4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_SER4]),
    .stop_o(stop_serial4_o)
  );
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_SER2])) u_stop_ser2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_SER2]),
    .stop_o(stop_serial2_o)
  );
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_SER1])) u_stop_ser1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_SER1]),
    .stop_o(stop_serial1_o)
  );
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_SER0])) u_stop_ser0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_SER0]),
    .stop_o(stop_serial0_o)
  );

  // Two-wire bus channels
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_TW1])) u_stop_tw1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_TW1]),
    .stop_o(stop_twowire1_o)
  );
  msc_stop_flop #(.RST_VAL(RST_B[`MSC_BIT_TW0])) u_stop_tw0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_b_r[`MSC_BIT_TW0]),
    .stop_o(stop_twowire0_o)
  );

  // Serial channels in register C
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_SER5])) u_stop_ser5 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_SER5]),
    .stop_o(stop_serial5_o)
  );
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_SER6])) u_stop_ser6 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_SER6]),
    .stop_o(stop_serial6_o)
  );

  // 8-bit timer pairs in register C
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_T845])) u_stop_t845 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_T845]),
    .stop_o(stop_timer8_ch45_o)
  );
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_T867])) u_stop_t867 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_T867]),
    .stop_o(stop_timer8_ch67_o)
  );

  // USB and CRC units
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_USB])) u_stop_usb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_USB]),
    .stop_o(stop_usb_o)
  );
  msc_stop_flop #(.RST_VAL(RST_C[`MSC_BIT_CRC])) u_stop_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_BIT_CRC]),
    .stop_o(stop_crc_unit_o)
  );

  // RAM blocks; RAM stays usable out of reset
  msc_stop_flop #(.W(RAM_W), .RST_VAL(RST_C[`MSC_RAM_HI:`MSC_RAM_LO])) u_stop_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_i(module_stop_ctrl_c_r[`MSC_RAM_HI:`MSC_RAM_LO]),
    .stop_o(stop_ram_block_o)
  );

endmodule // msc_module_stop

// One registered stop line or group, one edge behind its register bits
module msc_stop_flop #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] stop_i,
  output logic [W-1:0] stop_o
);

  // Reset loads the register's own reset image so outputs and register agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stop_o <= RST_VAL;
    else
      stop_o <= stop_i;
  end

endmodule // msc_stop_flop

// >>> test/msc_module_stop_assertions.sv
`timescale 1ns/10ps
`include "msc_params.svh"
// Bus handshake and stop-output checks at the block's ports
module msc_module_stop_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [25:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic cpu_sleep_i,
  input wire logic stop_dma_ctrl_o,
  input wire logic stop_serial0_o,
  input wire logic stop_usb_o,
  input wire logic [4:0] stop_ram_block_o,
  input wire logic stop_bus_ctrl_o,
  input wire logic all_clock_stop_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr;
  // Full-width write taken at this edge
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[1:0] == 2'b11;
  sequence s_wa; wr && adr_i == `MSC_ADDR_A; endsequence
  sequence s_wb; wr && adr_i == `MSC_ADDR_B; endsequence
  sequence s_wc; wr && adr_i == `MSC_ADDR_C; endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack");
  a_dma_gate: assert property (s_wa |-> ##2 stop_dma_ctrl_o == $past(dat_i[13], 2))
    else $error("dma stop");
  a_mode_bit: assert property (s_wa |-> ##2 all_clock_stop_enable_o == $past(dat_i[15], 2))
    else $error("mode bit");
  a_serial_gate: assert property (s_wb |-> ##2 stop_serial0_o == $past(dat_i[8], 2))
    else $error("serial stop");
  a_usb_gate: assert property (s_wc |-> ##2 stop_usb_o == $past(dat_i[11], 2))
    else $error("usb stop");
  a_ram_gate: assert property (s_wc |-> ##2 stop_ram_block_o == $past(dat_i[4:0], 2))
    else $error("ram stop");
  a_bus_cause: assert property (stop_bus_ctrl_o |-> $past(cpu_sleep_i)
    && all_clock_stop_enable_o && stop_dma_ctrl_o && stop_usb_o) else $error("bus stop");
endmodule // msc_module_stop_chk
bind msc_module_stop msc_module_stop_chk u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .ack_o(ack_o),
  .cpu_sleep_i(cpu_sleep_i),
  .stop_dma_ctrl_o(stop_dma_ctrl_o),
  .stop_serial0_o(stop_serial0_o),
  .stop_usb_o(stop_usb_o),
  .stop_ram_block_o(stop_ram_block_o),
  .stop_bus_ctrl_o(stop_bus_ctrl_o),
  .all_clock_stop_enable_o(all_clock_stop_enable_o)
);

// >>> test/msc_periph_model.sv
`timescale 1ns/10ps
// Gated peripheral: activity counter runs only while its clock passes
module msc_periph_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_i,
  output logic [7:0] cnt_o
);
  // Stopped module holds its state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_o <= 8'h00;
    else if (!stop_i)
      cnt_o <= cnt_o + 8'h01;
  end
endmodule // msc_periph_model

// >>> test/msc_module_stop_tb_top.sv
`timescale 1ns/10ps
`include "msc_params.svh"
module msc_module_stop_tb_top;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, cpu_sleep_i, ack_o;
  logic [25:0] adr_i;
  wire [25:0] so;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  wire [1:0] bp;
  logic [7:0] pc, v;
  logic [31:0] q;
  logic [15:0] sh [3];
  int err_total, checks;
  localparam logic [25:0] AD [3] = '{`MSC_ADDR_A, `MSC_ADDR_B, `MSC_ADDR_C};
  localparam logic [15:0] MK [3] = '{`MSC_MASK_A, `MSC_MASK_B, `MSC_MASK_C};
  localparam logic [15:0] PT [4] = '{16'hFFFF, 16'h0000, 16'hA5A5, 16'h5A5A};
  msc_module_stop u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .cpu_sleep_i, .all_clock_stop_enable_o(so[25]), .stop_dma_ctrl_o(so[24]),
    .stop_transfer_ctrl_o(so[23]), .stop_timer8_ch32_o(so[22]), .stop_timer8_ch10_o(so[21]),
    .stop_dac_o(so[20]), .stop_adc_o(so[19]), .stop_pulse_timer_o(so[18]),
    .stop_pulse_generator_o(so[17]), .stop_serial4_o(so[16]), .stop_serial2_o(so[15]),
    .stop_serial1_o(so[14]), .stop_serial0_o(so[13]), .stop_twowire1_o(so[12]),
    .stop_twowire0_o(so[11]), .stop_serial5_o(so[10]), .stop_serial6_o(so[9]),
    .stop_timer8_ch45_o(so[8]), .stop_timer8_ch67_o(so[7]), .stop_usb_o(so[6]),
    .stop_crc_unit_o(so[5]), .stop_ram_block_o(so[4:0]), .stop_bus_ctrl_o(bp[1]),
    .stop_io_ports_o(bp[0]));
  msc_periph_model u_dma_model (.clk_i, .rst_i, .stop_i(so[24]), .cnt_o(pc));
  // Expected stop outputs from the three register values
  function automatic logic [25:0] ex(input logic [15:0] a, b, c);
    return {a[15], a[13:12], a[9:8], a[5], a[3], a[0], b[15], b[12], b[10:6], c[15:10], c[4:0]};
  endfunction
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [25:0] a, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    chk({31'h0, ack_o}, 32'h0);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {16'h0000, d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr_rd(input int i, input logic [15:0] d);
    wb(1'b1, AD[i], d, 4'hF);
    sh[i] = d & MK[i];
    wb(1'b0, AD[i], 16'h0000, 4'hF);
    chk(q, {16'h0000, sh[i]});
    chk({6'h00, so}, {6'h00, ex(sh[0], sh[1], sh[2])});
  endtask
  task automatic t_reset;
    sh = '{`MSC_RST_A, `MSC_RST_B, `MSC_RST_C};
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b0, AD[i], 16'h0000, 4'hF);
      chk(q, {16'h0000, sh[i]});
    end
    wb(1'b1, 26'h0000010, 16'hFFFF, 4'hF);
    wb(1'b0, 26'h0000010, 16'h0000, 4'hF);
    chk(q, 32'h00000000);
    chk({6'h00, so}, {6'h00, ex(sh[0], sh[1], sh[2])});
    chk({30'h0, bp}, 32'h00000000);
    $display("t_reset done");
  endtask
  task automatic t_bits;
    for (int i = 0; i < 3; i++)
      for (int p = 0; p < 4; p++)
        wr_rd(i, PT[p]);
    wb(1'b1, AD[0], 16'hFFFF, 4'h1);
    wb(1'b0, AD[0], 16'h0000, 4'hF);
    chk(q, {16'h0000, sh[0]});
    $display("t_bits done");
  endtask
  task automatic t_sleep;
    for (int i = 0; i < 3; i++)
      wr_rd(i, 16'hFFFF);
    cpu_sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({30'h0, bp}, 32'h00000003);
    wr_rd(2, 16'hFFFE);
    chk({30'h0, bp}, 32'h00000000);
    wr_rd(2, 16'hFFFF);
    wr_rd(0, 16'h7FFF);
    chk({30'h0, bp}, 32'h00000000);
    wr_rd(0, 16'hFFFF);
    chk({30'h0, bp}, 32'h00000003);
    cpu_sleep_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({30'h0, bp}, 32'h00000000);
    $display("t_sleep done");
  endtask
  task automatic t_model;
    wr_rd(0, 16'h0000);
    v = pc;
    repeat (4) @(posedge clk_i);
    chk({24'h0, pc}, {24'h0, v + 8'h04});
    wr_rd(0, 16'hFFFF);
    v = pc;
    repeat (4) @(posedge clk_i);
    chk({24'h0, pc}, {24'h0, v});
    $display("t_model done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Main sequence
  initial
  begin
    {cyc_i, stb_i, we_i, cpu_sleep_i, adr_i, sel_i, dat_i} <= '0;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bits();
    t_sleep();
    t_model();
    give_verdict();
  end
  // Watchdog
  initial
  begin
    #250000;
    err_total++;
    give_verdict();
  end
endmodule // msc_module_stop_tb_top
